// >>> rtl/mff_top.v
// Frame framer and address filter for a 10 Mb/s media access controller.
// Operation
// - Transmit preamble of 62 alternating one-zero bits.
// - Receive aligns bytes after two consecutive ones.
// - First bit zero means individual; exact match.
// - Individual frames need full-width memory match unless promiscuous.
// - First bit one means group; exact match.
// - All-ones destination means all stations.
// - Promiscuous accepts every individual-addressed frame.
// - Acceptance classes enabled by control inputs.
// - Self-received source checked before its CRC.
// - Unmatched source sets monitored bad flag.
// - Length/type field passes untouched, unused.
// - No transmit padding, no oversize rejection.
// - Frames up to 64k bytes untruncated.
// - CRC uses the 32-bit AUTODIN II polynomial.
// - Frame check sequence appended only when enabled.
// - Check CRC of received and self-received frames.
// - Report whole-frame byte count per received frame.
// - Preamble and delimiter are stripped on receive.
// - Received check sequence bytes are delivered.
`timescale 1ns/1ps
`default_nettype none
`include "mff_regs.vh"

module mff_top (
  // Clock and reset.
  input  wire                  i_mclk,
  input  wire                  i_rst,
  // Transmit byte stream from the host.
  input  wire [7:0]            i_tx_data,
  input  wire                  i_tx_last,
  input  wire                  i_tx_valid,
  output wire                  o_tx_ready,
  input  wire                  i_tx_fcs_en,
  // Transmit status.
  output wire                  o_tx_busy,
  output reg                   o_tx_stat_valid,
  output reg                   o_tx_monitored_bad_flag,
  output reg                   o_tx_self_crc_ok,
  // Serial transmit path to the encoder.
  output reg                   o_tx_bit,
  output reg                   o_tx_en,
  // Serial receive path from the decoder.
  input  wire                  i_rx_crs,
  input  wire                  i_rx_bit_stb,
  input  wire                  i_rx_bit,
  // Receive acceptance controls.
  input  wire                  i_acc_ind,
  input  wire                  i_acc_group,
  input  wire                  i_acc_bcast,
  input  wire                  i_acc_promisc,
  // Received bytes and per-frame status.
  output reg  [7:0]            o_rx_data,
  output reg                   o_rx_byte_valid,
  output reg                   o_rx_stat_valid,
  output reg                   o_rx_accept,
  output reg                   o_rx_crc_ok,
  output reg                   o_rx_is_group,
  output reg                   o_rx_is_bcast,
  output reg                   o_rx_align_err,
  output reg  [15:0]           o_rx_frame_byte_count_field,
  // Station address memory write port.
  input  wire                  i_am_we,
  input  wire [`MFF_AM_AW-1:0] i_am_idx,
  input  wire [`MFF_ADDR_W-1:0] i_am_addr,
  input  wire                  i_am_en
);

  // Cycles per serial bit, derived from the link and clock periods.
  localparam integer BIT_DIV = `MFF_BIT_NS / `MFF_CLK_NS;
  localparam [7:0]   BIT_DIV_M1 = BIT_DIV[7:0] - 8'h01;

  // Transmit states.
  localparam [3:0] TX_IDLE = 4'h1;
  localparam [3:0] TX_PRE  = 4'h2;
  localparam [3:0] TX_DATA = 4'h4;
  localparam [3:0] TX_FCS  = 4'h8;

  // Receive states.
  localparam [2:0] RX_IDLE = 3'h1;
  localparam [2:0] RX_PRE  = 3'h2;
  localparam [2:0] RX_DATA = 3'h4;

  // One serial bit step of the reflected CRC register.
  function [31:0] crc_step;
    input [31:0] c;
    input        b;
    begin
      if (c[0] ^ b) begin
        crc_step = {1'b0, c[31:1]} ^ `MFF_CRC_POLY;
      end else begin
        crc_step = {1'b0, c[31:1]};
      end
    end
  endfunction

  // ---------------- Transmit buffer ----------------
  wire [7:0] fifo_data;
  wire       fifo_last;
  wire       fifo_valid;
  reg        fifo_pop;

  // Host bytes are taken verbatim, source address included.
  mff_fifo #(
    .W  (`MFF_FIFO_W),
    .D  (`MFF_FIFO_DEPTH),
    .AW (`MFF_FIFO_AW)
  ) u_tx_fifo (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_in_data   ({i_tx_last, i_tx_data}),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .o_out_data  ({fifo_last, fifo_data}),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop)
  );

  // ---------------- Bit-rate divider ----------------
  reg [7:0] div_r;
  wire      bit_en = (div_r == 8'h00);

  // Free-running divider makes a one-cycle enable per serial bit.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= 8'h00;
    end else if (bit_en) begin
      div_r <= BIT_DIV_M1;
    end else begin
      div_r <= div_r - 8'h01;
    end
  end

  // ---------------- Transmit serializer ----------------
  reg [3:0]  tx_st_r;
  reg [5:0]  tx_cnt_r;
  reg [7:0]  tx_sr_r;
  reg        tx_last_r;
  reg        tx_fcs_r;
  reg [31:0] tx_crc_r;

  assign o_tx_busy = (tx_st_r != TX_IDLE) | o_tx_en;

  // Pop the buffer whenever a byte is loaded into the shifter.
  always @* begin
    fifo_pop = 1'b0;
    if (bit_en & fifo_valid) begin
      if ((tx_st_r == TX_PRE) & (tx_cnt_r == `MFF_PRE_LAST)) begin
        fifo_pop = 1'b1;
      end else if ((tx_st_r == TX_DATA) & (tx_cnt_r[2:0] == 3'h7) & ~tx_last_r) begin
        fifo_pop = 1'b1;
      end
    end
  end

  // Serializer sends preamble, delimiter, data LSB first, then optional FCS.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_st_r   <= TX_IDLE;
      tx_cnt_r  <= 6'h00;
      tx_sr_r   <= 8'h00;
      tx_last_r <= 1'b0;
      tx_fcs_r  <= 1'b0;
      tx_crc_r  <= `MFF_CRC_INIT;
      o_tx_bit  <= 1'b0;
      o_tx_en   <= 1'b0;
    end else if (bit_en) begin
      case (tx_st_r)
        TX_IDLE: begin
          o_tx_bit <= 1'b0;
          o_tx_en  <= 1'b0;
          if (fifo_valid) begin
            o_tx_bit <= 1'b1;
            o_tx_en  <= 1'b1;
            tx_fcs_r <= i_tx_fcs_en;
            tx_cnt_r <= 6'h01;
            tx_st_r  <= TX_PRE;
          end
        end
        TX_PRE: begin
          // Alternating bits first, then the two delimiter ones.
          o_tx_bit <= (tx_cnt_r < `MFF_PRE_BITS) ? ~tx_cnt_r[0] : 1'b1;
          o_tx_en  <= 1'b1;
          tx_cnt_r <= tx_cnt_r + 6'h01;
          if (tx_cnt_r == `MFF_PRE_LAST) begin
            tx_sr_r   <= fifo_data;
            tx_last_r <= fifo_last | ~fifo_valid;
            tx_crc_r  <= `MFF_CRC_INIT;
            tx_cnt_r  <= 6'h00;
            tx_st_r   <= TX_DATA;
          end
        end
        TX_DATA: begin
          // Frames end where the host ends them, with no padding.
          o_tx_bit <= tx_sr_r[0];
          o_tx_en  <= 1'b1;
          tx_crc_r <= crc_step(tx_crc_r, tx_sr_r[0]);
          tx_sr_r  <= {1'b0, tx_sr_r[7:1]};
          tx_cnt_r <= tx_cnt_r + 6'h01;
          if (tx_cnt_r[2:0] == 3'h7) begin
            tx_cnt_r <= 6'h00;
            if (tx_last_r | ~fifo_valid) begin
              tx_st_r <= tx_fcs_r ? TX_FCS : TX_IDLE;
            end else begin
              tx_sr_r   <= fifo_data;
              tx_last_r <= fifo_last;
            end
          end
        end
        TX_FCS: begin
          // Complemented register goes out LSB first.
          o_tx_bit <= ~tx_crc_r[0];
          o_tx_en  <= 1'b1;
          tx_crc_r <= {1'b1, tx_crc_r[31:1]};
          tx_cnt_r <= tx_cnt_r + 6'h01;
          if (tx_cnt_r == 6'h1F) begin
            tx_st_r <= TX_IDLE;
          end
        end
        default: begin
          tx_st_r <= TX_IDLE;
          o_tx_en <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- Station address memory and scan ----------------
  reg  [4:0]            scan_cnt_r;
  reg                   scan_busy_r;
  reg                   scan_sa_r;
  wire [`MFF_AM_W-1:0]  am_rdata;
  reg  [`MFF_ADDR_W-1:0] da_r;
  reg  [`MFF_ADDR_W-1:0] sa_r;
  reg                   da_hit_r;
  reg                   sa_hit_r;
  reg                   sa_done_r;

  mff_addr_mem u_addr_mem (
    .i_mclk  (i_mclk),
    .i_we    (i_am_we),
    .i_widx  (i_am_idx),
    .i_wdata ({i_am_en, i_am_addr}),
    .i_ridx  (scan_cnt_r[3:0]),
    .o_rdata (am_rdata)
  );

  // Entry compared this cycle was read on the previous one; full width only.
  wire [`MFF_ADDR_W-1:0] scan_key = scan_sa_r ? sa_r : da_r;
  wire scan_cmp = scan_busy_r & (scan_cnt_r != 5'h00);
  wire scan_eq  = am_rdata[`MFF_AM_VALID] & (am_rdata[`MFF_ADDR_W-1:0] == scan_key);

  // ---------------- Receive deframer ----------------
  reg [2:0]  rx_st_r;
  reg        rx_prev_r;
  reg [2:0]  rx_bitc_r;
  reg [7:0]  rx_sr_r;
  reg [15:0] rx_bytes_r;
  reg [31:0] rx_crc_r;
  reg        rx_self_r;

  wire [7:0]  rx_byte   = {i_rx_bit, rx_sr_r[7:1]};
  wire [15:0] rx_bytes1 = rx_bytes_r + 16'h0001;
  wire [2:0]  sa_slot   = rx_bytes_r[2:0] - 3'h6;
  wire        da_group  = da_r[0];
  wire        da_bcast  = &da_r;

  // Scan runs sixteen reads after the destination address lands, and after the source address of a self-received frame.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      scan_busy_r <= 1'b0;
      scan_cnt_r  <= 5'h00;
      scan_sa_r   <= 1'b0;
      da_hit_r    <= 1'b0;
      sa_hit_r    <= 1'b0;
      sa_done_r   <= 1'b0;
    end else begin
      if ((rx_st_r == RX_PRE) & i_rx_bit_stb & i_rx_bit & rx_prev_r) begin
        da_hit_r  <= 1'b0;
        sa_hit_r  <= 1'b0;
        sa_done_r <= 1'b0;
      end
      if (scan_cmp & scan_eq) begin
        if (scan_sa_r) begin
          sa_hit_r <= 1'b1;
        end else begin
          da_hit_r <= 1'b1;
        end
      end
      if (scan_busy_r) begin
        scan_cnt_r <= scan_cnt_r + 5'h01;
        if (scan_cnt_r == 5'h10) begin
          scan_busy_r <= 1'b0;
          sa_done_r   <= scan_sa_r;
        end
      end else if ((rx_st_r == RX_DATA) & i_rx_bit_stb & (rx_bitc_r == 3'h7)) begin
        if (rx_bytes1 == `MFF_DA_END) begin
          scan_busy_r <= 1'b1;
          scan_cnt_r  <= 5'h00;
          scan_sa_r   <= 1'b0;
        end else if ((rx_bytes1 == `MFF_SA_END) & rx_self_r) begin
          scan_busy_r <= 1'b1;
          scan_cnt_r  <= 5'h00;
          scan_sa_r   <= 1'b1;
        end
      end
    end
  end

  // Deframer hunts the delimiter, shifts bytes in, counts and checks them.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_st_r         <= RX_IDLE;
      rx_prev_r       <= 1'b0;
      rx_bitc_r       <= 3'h0;
      rx_sr_r         <= 8'h00;
      rx_bytes_r      <= 16'h0000;
      rx_crc_r        <= `MFF_CRC_INIT;
      rx_self_r       <= 1'b0;
      da_r            <= {`MFF_ADDR_W{1'b0}};
      sa_r            <= {`MFF_ADDR_W{1'b0}};
      o_rx_data       <= 8'h00;
      o_rx_byte_valid <= 1'b0;
    end else begin
      o_rx_byte_valid <= 1'b0;
      case (rx_st_r)
        RX_IDLE: begin
          rx_prev_r <= 1'b0;
          if (i_rx_crs) begin
            rx_st_r <= RX_PRE;
          end
        end
        RX_PRE: begin
          // Preamble bits are consumed here and never delivered.
          if (~i_rx_crs) begin
            rx_st_r <= RX_IDLE;
          end else if (i_rx_bit_stb) begin
            rx_prev_r <= i_rx_bit;
            if (i_rx_bit & rx_prev_r) begin
              rx_st_r    <= RX_DATA;
              rx_bitc_r  <= 3'h0;
              rx_bytes_r <= 16'h0000;
              rx_crc_r   <= `MFF_CRC_INIT;
              rx_self_r  <= o_tx_busy;
            end
          end
        end
        RX_DATA: begin
          if (~i_rx_crs) begin
            rx_st_r <= RX_IDLE;
          end else if (i_rx_bit_stb) begin
            rx_sr_r   <= rx_byte;
            rx_crc_r  <= crc_step(rx_crc_r, i_rx_bit);
            rx_bitc_r <= rx_bitc_r + 3'h1;
            if (rx_bitc_r == 3'h7) begin
              // Every byte of a frame that is not self-received, check sequence included, goes out.
              o_rx_data       <= rx_byte;
              o_rx_byte_valid <= ~rx_self_r;
              rx_bytes_r      <= rx_bytes1;
              if (rx_bytes_r < `MFF_DA_END) begin
                da_r[{rx_bytes_r[2:0], 3'b000} +: 8] <= rx_byte;
              end else if (rx_bytes_r < `MFF_SA_END) begin
                sa_r[{sa_slot, 3'b000} +: 8] <= rx_byte;
              end
            end
          end
        end
        default: begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // Acceptance decision from the address class and the enabled classes.
  wire rx_ind_ok = ~da_group & ((i_acc_ind & da_hit_r) | i_acc_promisc);
  wire rx_grp_ok = da_group & ~da_bcast & i_acc_group & da_hit_r;
  wire rx_bc_ok  = da_bcast & (i_acc_bcast | (i_acc_group & da_hit_r));
  wire rx_end    = (rx_st_r == RX_DATA) & ~i_rx_crs;
  wire rx_good   = (rx_crc_r == `MFF_CRC_RESIDUE);
  wire rx_full   = (rx_bytes_r >= `MFF_DA_END);

  // Frame-end status; oversize frames are never flagged.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_stat_valid             <= 1'b0;
      o_rx_accept                 <= 1'b0;
      o_rx_crc_ok                 <= 1'b0;
      o_rx_is_group               <= 1'b0;
      o_rx_is_bcast               <= 1'b0;
      o_rx_align_err              <= 1'b0;
      o_rx_frame_byte_count_field <= 16'h0000;
      o_tx_stat_valid             <= 1'b0;
      o_tx_monitored_bad_flag     <= 1'b0;
      o_tx_self_crc_ok            <= 1'b0;
    end else begin
      o_rx_stat_valid <= 1'b0;
      o_tx_stat_valid <= 1'b0;
      if (rx_end & ~rx_self_r) begin
        o_rx_stat_valid             <= 1'b1;
        o_rx_accept                 <= rx_full & (rx_ind_ok | rx_grp_ok | rx_bc_ok);
        o_rx_crc_ok                 <= rx_good;
        o_rx_is_group               <= da_group;
        o_rx_is_bcast               <= da_bcast;
        o_rx_align_err              <= (rx_bitc_r != 3'h0);
        o_rx_frame_byte_count_field <= rx_bytes_r;
      end
      if (rx_end & rx_self_r) begin
        // Source result was settled by the scan before the CRC is judged.
        o_tx_stat_valid         <= 1'b1;
        o_tx_monitored_bad_flag <= ~(sa_done_r & sa_hit_r);
        o_tx_self_crc_ok        <= rx_good;
      end
    end
  end

endmodule

`default_nettype wire

// >>> common/mff_regs.vh
// Constants for the frame format and address filter block.
`ifndef MFF_REGS_VH
`define MFF_REGS_VH

// Link timing: one serial bit every 100 ns on a 5 ns clock.
`define MFF_BIT_NS      100
`define MFF_CLK_NS      5

// Preamble length in alternating bits, and count index of the last of the two delimiter ones.
`define MFF_PRE_BITS    6'd62
`define MFF_PRE_LAST    6'd63

// Frame check sequence generator, bit-reflected form.
`define MFF_CRC_INIT    32'hFFFFFFFF
`define MFF_CRC_POLY    32'hEDB88320
`define MFF_CRC_RESIDUE 32'hDEBB20E3

// Station address memory shape.
`define MFF_AM_DEPTH    16
`define MFF_AM_AW       4
`define MFF_ADDR_W      48
`define MFF_AM_W        49
`define MFF_AM_VALID    48

// Byte positions of the destination and source address ends.
`define MFF_DA_END      16'h0006
`define MFF_SA_END      16'h000C

// Transmit buffer shape: eight data bits plus a last flag.
`define MFF_FIFO_W      9
`define MFF_FIFO_DEPTH  16
`define MFF_FIFO_AW     4

`endif

// >>> rtl/mff_fifo.v
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module mff_fifo #(
  parameter W  = 9,
  parameter D  = 16,
  parameter AW = 4
) (
  // Clock and reset.
  input  wire          i_mclk,
  input  wire          i_rst,
  // Fill side.
  input  wire [W-1:0]  i_in_data,
  input  wire          i_in_valid,
  output wire          o_in_ready,
  // Drain side.
  output wire [W-1:0]  o_out_data,
  output wire          o_out_valid,
  input  wire          i_out_ready
);

  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0]   count_r;

  wire push = i_in_valid & o_in_ready;
  wire pop  = o_out_valid & i_out_ready;

  // Full and empty come straight from the occupancy count.
  assign o_in_ready  = (count_r != D[AW:0]);
  assign o_out_valid = (count_r != {(AW+1){1'b0}});
  assign o_out_data  = mem_r[rptr_r];

  // Storage array is written only on an accepted push.
  always @(posedge i_mclk) begin
    if (push) begin
      mem_r[wptr_r] <= i_in_data;
    end
  end

  // Pointers wrap naturally since the depth is a power of two.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wptr_r  <= {AW{1'b0}};
      rptr_r  <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/mff_addr_mem.v
// Station address memory with one write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none
`include "mff_regs.vh"

module mff_addr_mem (
  // Clock.
  input  wire                  i_mclk,
  // Write port, entry valid bit on top.
  input  wire                  i_we,
  input  wire [`MFF_AM_AW-1:0] i_widx,
  input  wire [`MFF_AM_W-1:0]  i_wdata,
  // Read port, data one cycle after the index.
  input  wire [`MFF_AM_AW-1:0] i_ridx,
  output reg  [`MFF_AM_W-1:0]  o_rdata
);

  reg [`MFF_AM_W-1:0] mem_r [0:`MFF_AM_DEPTH-1];

  // Write and registered read share the clock.
  always @(posedge i_mclk) begin
    if (i_we) begin
      mem_r[i_widx] <= i_wdata;
    end
    o_rdata <= mem_r[i_ridx];
  end

endmodule

`default_nettype wire

// >>> sim/mff_top_sva.sv
// Concurrent checks on the frame block's ports.
`timescale 1ns/1ps
`default_nettype none
module mff_top_chk (
  // Clock and reset.
  input wire logic        i_mclk,
  input wire logic        i_rst,
  // Receive side.
  input wire logic        i_rx_crs,
  input wire logic        i_rx_bit_stb,
  input wire logic        i_acc_ind,
  input wire logic        i_acc_group,
  input wire logic        i_acc_bcast,
  input wire logic        i_acc_promisc,
  input wire logic        o_rx_byte_valid,
  input wire logic        o_rx_stat_valid,
  input wire logic        o_rx_accept,
  input wire logic        o_rx_is_group,
  input wire logic        o_rx_is_bcast,
  input wire logic [15:0] o_rx_frame_byte_count_field,
  // Transmit side.
  input wire logic        o_tx_busy,
  input wire logic        o_tx_en,
  input wire logic        o_tx_bit,
  input wire logic        o_tx_stat_valid
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic st;
  logic big;
  // Status strobe, and frames long enough to hold a whole destination address.
  assign st  = o_rx_stat_valid;
  assign big = o_rx_frame_byte_count_field >= 16'h0006;
  // A frame opens with a one that holds for at least nine clock cycles.
  sequence s_first_bit;
    o_tx_bit ##1 (o_tx_en && $stable(o_tx_bit)) [*8];
  endsequence
  a_pre_first: assert property ($rose(o_tx_en) |-> s_first_bit)
    else $error("preamble start wrong");
  a_pre_second: assert property ($rose(o_tx_en) |-> ##20 (o_tx_en && !o_tx_bit))
    else $error("preamble second bit wrong");
  a_en_busy: assert property ($fell(o_tx_en) |-> !o_tx_busy)
    else $error("busy after sending ended");
  a_byte_strobe: assert property (o_rx_byte_valid |-> $past(i_rx_bit_stb) && $past(i_rx_crs))
    else $error("byte without a bit strobe");
  a_rx_stat_end: assert property (st |-> !$past(i_rx_crs))
    else $error("receive status before carrier end");
  a_tx_stat_end: assert property (o_tx_stat_valid |-> !$past(i_rx_crs))
    else $error("transmit status before carrier end");
  a_bcast_group: assert property (st && o_rx_is_bcast |-> o_rx_is_group)
    else $error("all-station not group");
  a_promisc_ind: assert property (st && !o_rx_is_group && i_acc_promisc && big |-> o_rx_accept)
    else $error("promiscuous frame dropped");
  a_ind_off: assert property (st && !o_rx_is_group && !i_acc_ind && !i_acc_promisc |-> !o_rx_accept)
    else $error("individual frame taken while off");
  a_group_off: assert property (st && o_rx_is_group && !o_rx_is_bcast && !i_acc_group |-> !o_rx_accept)
    else $error("group frame taken while off");
  a_bcast_take: assert property (st && o_rx_is_bcast && i_acc_bcast && big |-> o_rx_accept)
    else $error("all-station frame dropped");
endmodule
bind mff_top mff_top_chk chk (.i_mclk, .i_rst, .i_rx_crs, .i_rx_bit_stb, .i_acc_ind,
  .i_acc_group, .i_acc_bcast, .i_acc_promisc, .o_rx_byte_valid, .o_rx_stat_valid,
  .o_rx_accept, .o_rx_is_group, .o_rx_is_bcast, .o_rx_frame_byte_count_field,
  .o_tx_busy, .o_tx_en, .o_tx_bit, .o_tx_stat_valid);
`default_nettype wire

// >>> sim/mff_far.sv
// Far-end model: loops transmit bits back and sends receive frames.
`timescale 1ns/1ps
`default_nettype none
module mff_far (
  // Clock.
  input  wire logic i_mclk,
  // Transmit serial path.
  input  wire logic i_tx_bit,
  input  wire logic i_tx_en,
  // Receive serial path.
  output var  logic o_crs,
  output var  logic o_stb,
  output var  logic o_bit
);
  logic [4:0] ph = 5'h00;
  logic       lb = 1'b0;
  logic       cap[$];
  initial begin
    o_crs = 1'b0;
    o_stb = 1'b0;
    o_bit = 1'b0;
  end
  // Echo each sent bit at mid-period; the idle data line toggles every cycle.
  always @(posedge i_mclk) begin
    if (i_tx_en) begin
      lb    <= 1'b1;
      ph    <= (ph == 5'd19) ? 5'd0 : ph + 5'd1;
      o_crs <= 1'b1;
      o_stb <= (ph == 5'd9);
      o_bit <= (ph == 5'd9) ? i_tx_bit : ~o_bit;
      if (ph == 5'd9) cap.push_back(i_tx_bit);
    end else if (lb) begin
      lb    <= 1'b0;
      ph    <= 5'h00;
      o_crs <= 1'b0;
      o_stb <= 1'b0;
    end
  end
  // Send preamble, delimiter and bytes LSB first, one strobed bit per 20 clocks.
  task automatic send(input logic [7:0] q[$]);
    logic b[$];
    for (int i = 0; i < 62; i++) b.push_back(~i[0]);
    b.push_back(1'b1);
    b.push_back(1'b1);
    foreach (q[i]) for (int k = 0; k < 8; k++) b.push_back(q[i][k]);
    o_crs <= 1'b1;
    foreach (b[i]) begin
      repeat (19) begin
        @(posedge i_mclk);
        o_stb <= 1'b0;
        o_bit <= ~o_bit;
      end
      @(posedge i_mclk);
      o_stb <= 1'b1;
      o_bit <= b[i];
    end
    @(posedge i_mclk);
    o_stb <= 1'b0;
    o_bit <= ~o_bit;
    repeat (4) @(posedge i_mclk);
    o_crs <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_mac_frame_format_filter.sv
// Self-checking bench of the frame framer and address filter.
`timescale 1ns/1ps
`default_nettype none
`include "mff_regs.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
module tb_mac_frame_format_filter;
  logic        i_mclk, i_rst, tx_last, tx_valid, tx_ready, fcs_en, tx_busy, tx_sv;
  logic        tx_bad, tx_crc, tx_bit, tx_en, crs, stb, rbit, am_we, am_en, rx_bv;
  logic        rx_sv, rx_acc, rx_crc, rx_grp, rx_bc, rx_al;
  logic [3:0]  acc, am_idx;
  logic [7:0]  tx_data, rx_data;
  logic [15:0] rx_cnt;
  logic [47:0] am_addr;
  logic [47:0] das[5];
  logic [7:0]  got[$];
  int          fails, compares, cyc;
  mff_top uut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_tx_data(tx_data), .i_tx_last(tx_last),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_fcs_en(fcs_en),
    .o_tx_busy(tx_busy), .o_tx_stat_valid(tx_sv), .o_tx_monitored_bad_flag(tx_bad),
    .o_tx_self_crc_ok(tx_crc), .o_tx_bit(tx_bit), .o_tx_en(tx_en), .i_rx_crs(crs),
    .i_rx_bit_stb(stb), .i_rx_bit(rbit), .i_acc_ind(acc[0]), .i_acc_group(acc[1]),
    .i_acc_bcast(acc[2]), .i_acc_promisc(acc[3]), .o_rx_data(rx_data),
    .o_rx_byte_valid(rx_bv), .o_rx_stat_valid(rx_sv), .o_rx_accept(rx_acc),
    .o_rx_crc_ok(rx_crc), .o_rx_is_group(rx_grp), .o_rx_is_bcast(rx_bc),
    .o_rx_align_err(rx_al), .o_rx_frame_byte_count_field(rx_cnt), .i_am_we(am_we),
    .i_am_idx(am_idx), .i_am_addr(am_addr), .i_am_en(am_en));
  mff_far far (.i_mclk(i_mclk), .i_tx_bit(tx_bit), .i_tx_en(tx_en), .o_crs(crs),
    .o_stb(stb), .o_bit(rbit));
  // Clock at 200 MHz.
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // Collect delivered bytes and cut a hang short.
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (rx_bv === 1'b1) got.push_back(rx_data);
    if (cyc == 90000) begin
      fails++;
      close_out();
    end
  end
  // Reflected frame check sequence, preset to ones, complemented at the end.
  function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
    logic [31:0] c;
    c = `MFF_CRC_INIT;
    foreach (q[i]) for (int k = 0; k < 8; k++)
      c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? `MFF_CRC_POLY : 32'h0);
    return ~c;
  endfunction
  // Addresses, then a random length/type field and payload.
  task automatic build(input logic [47:0] da, sa, input int n, output logic [7:0] q[$]);
    q = {};
    for (int i = 0; i < 12; i++) q.push_back(i < 6 ? da[8*i +: 8] : sa[8*i-48 +: 8]);
    repeat (n + 2) q.push_back(8'($urandom));
  endtask
  // Wait a bounded time for a status strobe.
  task automatic wait_for(ref logic s, input int n);
    repeat (n) begin
      @(posedge i_mclk);
      #1;
      if (s === 1'b1) break;
    end
    `CHK("status strobe", 1'b1, s)
  endtask
  // Hand a frame to the transmit buffer, holding each byte until it is taken.
  task automatic push(input logic [7:0] q[$]);
    foreach (q[i]) begin
      tx_data  <= q[i];
      tx_last  <= (i == q.size() - 1);
      tx_valid <= 1'b1;
      #1;
      while (tx_ready !== 1'b1) begin
        @(posedge i_mclk);
        #1;
      end
      @(posedge i_mclk);
    end
    tx_valid <= 1'b0;
  endtask
  // Receive one frame from the far end and compare with the filter model.
  task automatic rx_case(input int k);
    logic [7:0]  q[$];
    logic [31:0] f;
    logic        hit, grp, bc, ex;
    build(das[k % 5], das[1], 1 + $urandom % 3, q);
    f = crc_of(q);
    for (int i = 0; i < 4; i++) q.push_back(f[8*i +: 8]);
    if (k == 11) q[13] = ~q[13];
    acc <= (k < 5) ? 4'hF : (k < 10) ? 4'h0 : 4'($urandom);
    hit = (k % 5) inside {0, 2, 4};
    grp = das[k % 5][0];
    bc  = &das[k % 5];
    got.delete();
    far.send(q);
    wait_for(rx_sv, 50);
    ex = !grp ? (acc[0] & hit | acc[3]) : bc ? (acc[2] | acc[1] & hit) : (acc[1] & hit);
    `CHK("accept", ex, rx_acc)
    `CHK("group", grp, rx_grp)
    `CHK("bcast", bc, rx_bc)
    `CHK("crc ok", (k != 11), rx_crc)
    `CHK("align", 1'b0, rx_al)
    `CHK("count", 16'(q.size()), rx_cnt)
    `CHK("bytes", q.size(), got.size())
    foreach (q[i]) `CHK("byte", q[i], got[i])
    @(posedge i_mclk);
  endtask
  // Send one frame, watch the serial bits and the self-received status.
  task automatic tx_case(input logic [47:0] sa, input logic fe, input int n);
    logic [7:0]  q[$];
    logic        e[$];
    logic [31:0] f;
    build(das[0], sa, n, q);
    f = crc_of(q);
    for (int i = 0; i < 62; i++) e.push_back(~i[0]);
    e.push_back(1'b1);
    e.push_back(1'b1);
    foreach (q[i]) for (int k = 0; k < 8; k++) e.push_back(q[i][k]);
    if (fe) for (int k = 0; k < 32; k++) e.push_back(f[k]);
    far.cap.delete();
    got.delete();
    fcs_en <= fe;
    push(q);
    wait_for(tx_sv, 4000);
    `CHK("monitored bad", (sa !== das[0]), tx_bad)
    `CHK("self crc", fe, tx_crc)
    `CHK("bit total", e.size(), far.cap.size())
    foreach (e[i]) `CHK("bit", e[i], far.cap[i])
    `CHK("self bytes", 0, got.size())
    @(posedge i_mclk);
  endtask
  // Print the verdict and stop.
  task automatic close_out();
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset, load the address memory, then receive and transmit.
  initial begin
    das = '{48'h0000_5634_1202, 48'h0000_00AB_CD04, 48'h0000_0000_5E01,
            48'h0000_0000_7703, 48'hFFFF_FFFF_FFFF};
    {i_rst, tx_last, tx_valid, fcs_en, am_we, am_en} = 6'h20;
    {acc, am_idx, tx_data, am_addr} = '0;
    fails = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(32'h8246));
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      am_we   <= 1'b1;
      am_idx  <= 4'(i);
      am_addr <= (i < 5) ? das[i] : 48'($urandom);
      am_en   <= (i == 0 || i == 2 || i == 4);
      @(posedge i_mclk);
    end
    am_we <= 1'b0;
    for (int k = 0; k < 12; k++) rx_case(k);
    tx_case(das[0], 1'b1, 50);
    tx_case(das[1], 1'b0, 10);
    close_out();
  end
endmodule
`default_nettype wire
